// File: rtl/etcu_pkg.sv
/*
 * Shared constants for the event timer and compare unit: register indices, field
 * positions, reset values, counting modes, output actions and the output action helper.
 * Assumes one 125 MHz clock and a 5-bit word address on the register port.
 */
package etcu_pkg;

    // ---------------------------------------------------------------
    // sizes
    // ---------------------------------------------------------------
    localparam int NTMR = 3;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 5;
    localparam int DEAD_W = 8;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    // ---------------------------------------------------------------
    // register indices
    // ---------------------------------------------------------------
    localparam logic [ADDR_W-1:0] A_TMR_END = 5'h0C;
    localparam logic [1:0] OFS_CTRL = 2'h0;
    localparam logic [1:0] OFS_CNT = 2'h1;
    localparam logic [1:0] OFS_CMP = 2'h2;
    localparam logic [1:0] OFS_PER = 2'h3;
    localparam logic [ADDR_W-1:0] A_GCTRL = 5'h0C;
    localparam logic [ADDR_W-1:0] A_TOCR = 5'h0D;
    localparam logic [ADDR_W-1:0] A_FCMP0 = 5'h0E;
    localparam logic [ADDR_W-1:0] A_FACT = 5'h11;
    localparam logic [ADDR_W-1:0] A_DBCR = 5'h12;
    localparam logic [ADDR_W-1:0] A_SCMP0 = 5'h13;
    localparam logic [ADDR_W-1:0] A_SACT = 5'h16;
    localparam logic [ADDR_W-1:0] A_ISTAT = 5'h17;
    localparam logic [ADDR_W-1:0] A_IMASK = 5'h18;
    localparam logic [ADDR_W-1:0] A_TSTAT = 5'h19;

    // ---------------------------------------------------------------
    // fields
    // ---------------------------------------------------------------
    localparam int TC_MODE_LSB = 0;
    localparam int TC_PSC_LSB = 3;
    localparam int TC_EXT_BIT = 6;
    localparam int TC_W = 7;
    localparam int GC_CASC_BIT = 3;
    localparam int GC_STB_BIT = 4;
    localparam int GC_CAP_BIT = 5;
    localparam int GC_W = 6;
    localparam int F_UF = 0;
    localparam int F_OF = 1;
    localparam int F_CM = 2;
    localparam int F_PM = 3;
    localparam int NFLAG = 4;

    // ---------------------------------------------------------------
    // counting modes and output actions
    // ---------------------------------------------------------------
    localparam logic [2:0] M_STOP = 3'h0;
    localparam logic [2:0] M_SGL_UP = 3'h1;
    localparam logic [2:0] M_CONT_UP = 3'h2;
    localparam logic [2:0] M_DIR_UD = 3'h3;
    localparam logic [2:0] M_CONT_UD = 3'h4;
    localparam logic [2:0] M_SGL_UD = 3'h5;
    localparam logic [1:0] ACT_LOW = 2'h0;
    localparam logic [1:0] ACT_ALO = 2'h1;
    localparam logic [1:0] ACT_AHI = 2'h2;
    localparam logic [1:0] ACT_HIGH = 2'h3;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [CNT_W-1:0] RST_PER = 16'hFFFF;

    function automatic logic etcu_drive(input logic [1:0] act, input logic lvl);
        case (act)
            ACT_LOW: return 1'b0;
            ACT_ALO: return ~lvl;
            ACT_AHI: return lvl;
            default: return 1'b1;
        endcase
    endfunction

endpackage

// File: rtl/etcu_cells.sv
/*
 * Leaf cells of the event timer and compare unit: one general-purpose timer and
 * one deadband pair generator. Both are instantiated from etcu_top.
 * Assumes all inputs synchronous to clk_i and shadow values held by the parent.
 */
// Added by the designer: the placing of the registers and the plain strobed port.
module etcu_timer import etcu_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic [2:0] mode_i,
    input wire logic [2:0] psc_i,
    input wire logic ext_sel_i,
    input wire logic casc_sel_i,
    input wire logic carry_i,
    input wire logic ext_clk_i,
    input wire logic dir_i,
    input wire logic cnt_wr_i,
    input wire logic [CNT_W-1:0] cnt_wdata_i,
    input wire logic [CNT_W-1:0] cmp_sh_i,
    input wire logic [CNT_W-1:0] per_sh_i,
    output logic [CNT_W-1:0] cnt_o,
    output logic wrap_o,
    output logic load_o,
    output logic [NFLAG-1:0] flags_o,
    output logic done_o,
    output logic down_o,
    output logic pwm_o
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] cmp;
        logic [CNT_W-1:0] per;
        logic down;
        logic [6:0] psc;
        logic ext_q;
        logic [NFLAG-1:0] flags;
        logic wrap;
        logic load;
        logic done;
    } etcu_tmr_t;

    etcu_tmr_t q, d;
    logic src, tick, bnd;
    logic [7:0] lim;
    logic [CNT_W-1:0] nxt;

    always_comb begin
        d = q;
        d.flags = '0;
        d.wrap = 1'b0;
        d.done = 1'b0;
        d.ext_q = ext_clk_i;
        tick = 1'b0;
        bnd = 1'b0;
        nxt = q.cnt;
        // source: carry of the lower half, external edge, or every cycle
        src = casc_sel_i ? carry_i : (ext_sel_i ? (ext_clk_i & ~q.ext_q) : 1'b1);
        lim = (8'h01 << psc_i) - 8'h01;
        if (run_i && src) begin
            if ({1'b0, q.psc} >= lim) begin
                d.psc = '0;
                tick = 1'b1;
            end else begin
                d.psc = q.psc + 7'h01;
            end
        end
        if (tick) begin
            case (mode_i)
                M_SGL_UP, M_CONT_UP: begin
                    if (q.cnt == q.per) begin
                        nxt = '0;
                        d.flags[F_PM] = 1'b1;
                        d.wrap = 1'b1;
                        bnd = 1'b1;
                        d.done = (mode_i == M_SGL_UP);
                    end else begin
                        nxt = q.cnt + CNT_ONE;
                    end
                    if (q.cnt == CNT_MAX) begin
                        d.flags[F_OF] = 1'b1;
                        bnd = 1'b1;
                    end
                end
                M_CONT_UD, M_SGL_UD: begin
                    if (!q.down) begin
                        if (q.cnt >= q.per) begin
                            d.down = (q.cnt != '0);
                            nxt = (q.cnt != '0) ? q.cnt - CNT_ONE : q.cnt;
                            d.flags[F_PM] = 1'b1;
                            bnd = 1'b1;
                        end else begin
                            nxt = q.cnt + CNT_ONE;
                        end
                    end else if (q.cnt == '0) begin
                        d.down = 1'b0;
                        d.flags[F_UF] = 1'b1;
                        d.wrap = 1'b1;
                        bnd = 1'b1;
                        d.done = (mode_i == M_SGL_UD);
                        nxt = (mode_i == M_SGL_UD) ? q.cnt : q.cnt + CNT_ONE;
                    end else begin
                        nxt = q.cnt - CNT_ONE;
                    end
                end
                M_DIR_UD: begin
                    d.down = ~dir_i;
                    if (dir_i) begin
                        if (q.cnt == q.per) begin
                            nxt = '0;
                            d.flags[F_PM] = 1'b1;
                            d.wrap = 1'b1;
                            bnd = 1'b1;
                        end else begin
                            nxt = q.cnt + CNT_ONE;
                        end
                        d.flags[F_OF] = (q.cnt == CNT_MAX);
                    end else if (q.cnt == '0) begin
                        nxt = q.per;
                        d.flags[F_UF] = 1'b1;
                        bnd = 1'b1;
                    end else begin
                        nxt = q.cnt - CNT_ONE;
                    end
                end
                default: ;
            endcase
            d.flags[F_CM] = (nxt == q.cmp) && (nxt != q.cnt);
        end
        d.cnt = nxt;
        if (cnt_wr_i) begin
            d.cnt = cnt_wdata_i;
            d.down = 1'b0;
        end
        // shadow copies go live only at a boundary or while stopped, avoiding glitches
        d.load = bnd || !run_i;
        if (d.load) begin
            d.cmp = cmp_sh_i;
            d.per = per_sh_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.per <= RST_PER;
        end else begin
            q <= d;
        end
    end

    assign cnt_o = q.cnt;
    assign wrap_o = q.wrap;
    assign load_o = q.load;
    assign flags_o = q.flags;
    assign done_o = q.done;
    assign down_o = q.down;
    assign pwm_o = (q.cnt >= q.cmp);

endmodule // etcu_timer

module etcu_deadband import etcu_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ref_i,
    input wire logic [DEAD_W-1:0] dead_i,
    output logic hi_o,
    output logic lo_o
);
    typedef struct packed {
        logic prev;
        logic [DEAD_W-1:0] cnt;
        logic hi;
        logic lo;
    } etcu_db_t;

    etcu_db_t q, d;

    always_comb begin
        d = q;
        d.prev = ref_i;
        // any edge drops both sides first, so the pair can never overlap
        if (ref_i != q.prev) begin
            d.cnt = dead_i;
            d.hi = 1'b0;
            d.lo = 1'b0;
        end else if (q.cnt != '0) begin
            d.cnt = q.cnt - 8'h01;
        end else begin
            d.hi = q.prev;
            d.lo = ~q.prev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign hi_o = q.hi;
    assign lo_o = q.lo;

endmodule // etcu_deadband

// File: rtl/etcu_top.sv
/*
 * Top of the event timer and compare unit: register file, three timers, three full
 * compares with deadband pairs, three simple compares and the interrupt status.
 * Assumes a master that issues one-cycle strobes and synchronous pin inputs.
 */

// How it works
// - 16-bit counters count up or up/down
// - active compare value backed by writable shadow
// - active period value backed by writable shadow
// - internal or external clock through prescaler
// - four maskable flags: underflow, overflow, compare, period
// - timer output polarity selectable low or high
// - direction pin steers directional up/down mode
// - timers two and three cascade to 32 bits
// - timers run independently or start together
// - five modes: two single, three continuous
// - compare register gives events and PWM
// - output control register sets timer outputs
// - timebases routed to compares and capture side
// - three full compares, six deadbanded outputs
// - each full compare output configured alone
// - three simple compares on timer one/two
// - simple outputs: active low/high, forced low/high
module etcu_top import etcu_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [CNT_W-1:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [CNT_W-1:0] rdata_o,
    input wire logic [NTMR-1:0] tmr_ext_clk_i,
    input wire logic [NTMR-1:0] tmr_dir_i,
    output logic [NTMR-1:0] tmr_cmp_o,
    output logic [2*NTMR-1:0] full_cmp_o,
    output logic [NTMR-1:0] simple_cmp_o,
    output logic [CNT_W-1:0] cap_tb_o,
    output logic irq_o
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [NTMR-1:0][TC_W-1:0] tctrl;
        logic [NTMR-1:0][CNT_W-1:0] cmp_sh;
        logic [NTMR-1:0][CNT_W-1:0] per_sh;
        logic [GC_W-1:0] gctrl;
        logic [2*NTMR-1:0] tocr;
        logic [NTMR-1:0][CNT_W-1:0] fcmp_sh;
        logic [NTMR-1:0][CNT_W-1:0] fcmp_act;
        logic [4*NTMR-1:0] fact;
        logic [DEAD_W-1:0] dead;
        logic [NTMR-1:0][CNT_W-1:0] scmp_sh;
        logic [NTMR-1:0][CNT_W-1:0] scmp_act;
        logic [2*NTMR-1:0] sact;
        logic [NFLAG*NTMR-1:0] istat;
        logic [NFLAG*NTMR-1:0] imask;
        logic [CNT_W-1:0] rdata;
        logic [NTMR-1:0] tmr_out;
        logic [2*NTMR-1:0] full_out;
        logic [NTMR-1:0] simple_out;
        logic [CNT_W-1:0] cap_tb;
    } etcu_top_t;

    etcu_top_t q, d;

    logic [NTMR-1:0][CNT_W-1:0] cnt;
    logic [NTMR-1:0][NFLAG-1:0] flags;
    logic [NTMR-1:0] wrap, load, done, down, pwm, cnt_wr;
    logic [NTMR-1:0] fref, db_hi, db_lo;
    logic tmr_sel;
    logic [1:0] tidx, tofs;
    logic [CNT_W-1:0] stb_cnt;
    logic stb_load;

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    assign tmr_sel = (addr_i < A_TMR_END);
    assign tidx = addr_i[3:2];
    assign tofs = addr_i[1:0];

    // ---------------------------------------------------------------
    // timers
    // ---------------------------------------------------------------
    for (genvar g = 0; g < NTMR; g++) begin : g_tmr
        assign cnt_wr[g] = we_i && tmr_sel && (tidx == 2'(g)) && (tofs == OFS_CNT);
        etcu_timer u_tmr (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .run_i(q.gctrl[g]),
            .mode_i(q.tctrl[g][TC_MODE_LSB +: 3]),
            .psc_i(q.tctrl[g][TC_PSC_LSB +: 3]),
            .ext_sel_i(q.tctrl[g][TC_EXT_BIT]),
            .casc_sel_i((g == NTMR - 1) && q.gctrl[GC_CASC_BIT]),
            .carry_i(wrap[1]),
            .ext_clk_i(tmr_ext_clk_i[g]),
            .dir_i(tmr_dir_i[g]),
            .cnt_wr_i(cnt_wr[g]),
            .cnt_wdata_i(wdata_i),
            .cmp_sh_i(q.cmp_sh[g]),
            .per_sh_i(q.per_sh[g]),
            .cnt_o(cnt[g]),
            .wrap_o(wrap[g]),
            .load_o(load[g]),
            .flags_o(flags[g]),
            .done_o(done[g]),
            .down_o(down[g]),
            .pwm_o(pwm[g])
        );
    end

    // ---------------------------------------------------------------
    // full compares and deadband pairs
    // ---------------------------------------------------------------
    for (genvar k = 0; k < NTMR; k++) begin : g_full
        assign fref[k] = (cnt[0] >= q.fcmp_act[k]);
        etcu_deadband u_db (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .ref_i(fref[k]),
            .dead_i(q.dead),
            .hi_o(db_hi[k]),
            .lo_o(db_lo[k])
        );
    end

    // ---------------------------------------------------------------
    // simple compare timebase
    // ---------------------------------------------------------------
    assign stb_cnt = q.gctrl[GC_STB_BIT] ? cnt[1] : cnt[0];
    assign stb_load = q.gctrl[GC_STB_BIT] ? load[1] : load[0];

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        d = q;
        d.rdata = '0;
        // registers written by software
        if (we_i) begin
            if (tmr_sel) begin
                case (tofs)
                    OFS_CTRL: d.tctrl[tidx] = wdata_i[TC_W-1:0];
                    OFS_CMP: d.cmp_sh[tidx] = wdata_i;
                    OFS_PER: d.per_sh[tidx] = wdata_i;
                    default: ;
                endcase
            end else begin
                case (addr_i)
                    A_GCTRL: d.gctrl = wdata_i[GC_W-1:0];
                    A_TOCR: d.tocr = wdata_i[2*NTMR-1:0];
                    A_FCMP0, A_FCMP0 + 5'h01, A_FCMP0 + 5'h02: d.fcmp_sh[2'(addr_i - A_FCMP0)] = wdata_i;
                    A_FACT: d.fact = wdata_i[4*NTMR-1:0];
                    A_DBCR: d.dead = wdata_i[DEAD_W-1:0];
                    A_SCMP0, A_SCMP0 + 5'h01, A_SCMP0 + 5'h02: d.scmp_sh[2'(addr_i - A_SCMP0)] = wdata_i;
                    A_SACT: d.sact = wdata_i[2*NTMR-1:0];
                    A_IMASK: d.imask = wdata_i[NFLAG*NTMR-1:0];
                    default: ;
                endcase
            end
        end
        // a single-pass timer drops its own run bit when it ends
        for (int i = 0; i < NTMR; i++) begin
            if (done[i] && !(we_i && addr_i == A_GCTRL)) begin
                d.gctrl[i] = 1'b0;
            end
        end
        // sticky status: new events win over a write-one clear in the same cycle
        if (we_i && addr_i == A_ISTAT) begin
            d.istat = q.istat & ~wdata_i[NFLAG*NTMR-1:0];
        end
        d.istat = d.istat | {flags[2], flags[1], flags[0]};
        // compare values follow their timebase boundaries
        for (int i = 0; i < NTMR; i++) begin
            if (load[0]) begin
                d.fcmp_act[i] = q.fcmp_sh[i];
            end
            if (stb_load) begin
                d.scmp_act[i] = q.scmp_sh[i];
            end
        end
        // outputs are registered so pins change only on clock edges
        for (int i = 0; i < NTMR; i++) begin
            d.tmr_out[i] = etcu_drive(q.tocr[2*i +: 2], pwm[i]);
            d.full_out[2*i] = etcu_drive(q.fact[4*i +: 2], db_hi[i]);
            d.full_out[2*i+1] = etcu_drive(q.fact[4*i+2 +: 2], db_lo[i]);
            d.simple_out[i] = etcu_drive(q.sact[2*i +: 2], stb_cnt >= q.scmp_act[i]);
        end
        // capture side may use timer two or three only
        d.cap_tb = q.gctrl[GC_CAP_BIT] ? cnt[2] : cnt[1];
        // read data, valid the cycle after the strobe
        if (re_i) begin
            if (tmr_sel) begin
                case (tofs)
                    OFS_CTRL: d.rdata = CNT_W'(q.tctrl[tidx]);
                    OFS_CNT: d.rdata = cnt[tidx];
                    OFS_CMP: d.rdata = q.cmp_sh[tidx];
                    default: d.rdata = q.per_sh[tidx];
                endcase
            end else begin
                case (addr_i)
                    A_GCTRL: d.rdata = CNT_W'(q.gctrl);
                    A_TOCR: d.rdata = CNT_W'(q.tocr);
                    A_FCMP0, A_FCMP0 + 5'h01, A_FCMP0 + 5'h02: d.rdata = q.fcmp_sh[2'(addr_i - A_FCMP0)];
                    A_FACT: d.rdata = CNT_W'(q.fact);
                    A_DBCR: d.rdata = CNT_W'(q.dead);
                    A_SCMP0, A_SCMP0 + 5'h01, A_SCMP0 + 5'h02: d.rdata = q.scmp_sh[2'(addr_i - A_SCMP0)];
                    A_SACT: d.rdata = CNT_W'(q.sact);
                    A_ISTAT: d.rdata = CNT_W'(q.istat);
                    A_IMASK: d.rdata = CNT_W'(q.imask);
                    A_TSTAT: d.rdata = CNT_W'({pwm, down});
                    default: d.rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.per_sh <= {NTMR{RST_PER}};
        end else begin
            q <= d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign rdata_o = q.rdata;
    assign tmr_cmp_o = q.tmr_out;
    assign full_cmp_o = q.full_out;
    assign simple_cmp_o = q.simple_out;
    assign cap_tb_o = q.cap_tb;
    assign irq_o = |(q.istat & q.imask);

endmodule // etcu_top

// File: test/etcu_top_properties.sv
/* port assertions for etcu_top.
   assumes one clock and a synchronous active-low reset. */
module etcu_top_properties import etcu_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [CNT_W-1:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    input wire logic [CNT_W-1:0] rdata_o,
    input wire logic [NTMR-1:0] tmr_cmp_o,
    input wire logic [2*NTMR-1:0] full_cmp_o,
    input wire logic [NTMR-1:0] simple_cmp_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ----
    // helpers
    // ----
    // pairs settle a few cycles after an action change, so wait for age 3
    logic [11:0] fact_q;
    logic [1:0] age_q;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || (we_i && addr_i == A_FACT)) begin
            fact_q <= rst_n_i ? wdata_i[11:0] : 12'h000;
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    sequence tocr_wr; we_i && addr_i == A_TOCR; endsequence
    sequence tocr_rd; re_i && addr_i == A_TOCR; endsequence
    // ----
    // properties
    // ----
    rdata_idle_a: assert property (!$past(re_i) |-> rdata_o == 16'h0000)
        else $error("read data outside read slot");
    unmapped_zero_a: assert property (re_i && addr_i >= 5'h1A |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    reset_quiet_a: assert property ($rose(rst_n_i) |-> tmr_cmp_o == 3'h0 && full_cmp_o == 6'h00
        && simple_cmp_o == 3'h0 && !irq_o) else $error("outputs not quiet after reset");
    tocr_readback_a: assert property (tocr_wr ##2 tocr_rd |=> rdata_o == {10'h000, $past(wdata_i[5:0], 3)})
        else $error("output control readback wrong");
    mask_irq_a: assert property (we_i && addr_i == A_IMASK && wdata_i == 16'h0000 |=> !irq_o)
        else $error("masked interrupt still high");
    simple_forced_a: assert property (we_i && addr_i == A_SACT && wdata_i[5:0] == 6'h3F |->
        ##[1:3] simple_cmp_o == 3'h7) else $error("simple forced high missing");
    full_forced_a: assert property (we_i && addr_i == A_FACT && wdata_i[11:0] == 12'h000 |->
        ##[1:3] full_cmp_o == 6'h00) else $error("full forced low missing");
    pair_overlap_a: assert property (fact_q == 12'hAAA && age_q == 2'h3 |->
        (full_cmp_o & (full_cmp_o >> 1) & 6'h15) == 6'h00) else $error("pair sides overlap");
endmodule // etcu_top_properties

bind etcu_top etcu_top_properties u_props (.clk_i, .rst_n_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o,
    .tmr_cmp_o, .full_cmp_o, .simple_cmp_o, .irq_o);

// File: test/etcu_pins.sv
/* far-side model: direction and external count clock pins.
   assumes the bench sets the wanted direction and clock enable. */
module etcu_pins (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] dir_up_i,
    input wire logic ext_en_i,
    output logic [2:0] tmr_dir_o,
    output logic [2:0] tmr_ext_clk_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ph_q;
    initial begin
        tmr_dir_o = 3'h7;
        tmr_ext_clk_o = 3'h0;
        ph_q = 2'h0;
    end
    // clock stands still while disabled; one rising edge every 4 cycles
    always @(posedge clk_i) begin
        tmr_dir_o <= dir_up_i;
        ph_q <= (rst_n_i && ext_en_i) ? ph_q + 2'h1 : 2'h0;
        tmr_ext_clk_o <= {3{ph_q[1]}};
    end
endmodule // etcu_pins

// File: test/etcu_top_tb.sv
/* self-checking bench for etcu_top with the pin model.
   assumes the register map and action codes of etcu_pkg. */
module etcu_top_tb import etcu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    logic ext_en = 1'b0;
    logic p;
    logic [ADDR_W-1:0] addr_i = 5'h00;
    logic [CNT_W-1:0] wdata_i = 16'h0000;
    logic [CNT_W-1:0] rdata_o, cap_tb_o, d;
    logic [2:0] dir_up = 3'h7;
    logic [2:0] tmr_ext_clk_i, tmr_dir_i, tmr_cmp_o, simple_cmp_o;
    logic [5:0] full_cmp_o;
    logic irq_o;
    logic [31:0] seed = 32'h000088F5;
    int fails = 0;
    int checks = 0;
    int n, m;
    always #4 clk_i = ~clk_i;
    etcu_top uut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .tmr_ext_clk_i, .tmr_dir_i,
        .tmr_cmp_o, .full_cmp_o, .simple_cmp_o, .cap_tb_o, .irq_o);
    etcu_pins pins (.clk_i, .rst_n_i, .dir_up_i(dir_up), .ext_en_i(ext_en), .tmr_dir_o(tmr_dir_i),
        .tmr_ext_clk_o(tmr_ext_clk_i));
    // ----
    // helpers
    // ----
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [15:0] fill(input int c, input int k);
        fill = 16'h0000;
        for (int i = 0; i < k; i++) fill[2*i +: 2] = 2'(c);
    endfunction
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk_i);
        we_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk_i);
        re_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 d = rdata_o;
        chk(d, e);
    endtask
    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        give_verdict();
    end
    // ----
    // scenarios
    // ----
    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (n = 0; n < 3; n++) begin
            rdchk(5'(4*n+3), RST_PER);
            rdchk(5'(4*n), 16'h0000);
        end
        for (n = 26; n < 32; n++) begin
            wr(5'(n), 16'hFFFF);
            rdchk(5'(n), 16'h0000);
        end
        for (n = 0; n < 6; n++) begin
            seed = xs(seed);
            m = 4*(n%3) + 2 + n/3;
            wr(5'(m), seed[15:0]);
            rdchk(5'(m), seed[15:0]);
        end
        seed = xs(seed);
        wr(A_TOCR, seed[15:0]);
        rdchk(A_TOCR, seed[15:0] & 16'h003F);
        for (n = 0; n < 4; n += 3) begin
            wr(A_SACT, fill(n, 3));
            wr(A_FACT, fill(n, 6));
            wr(A_TOCR, fill(n, 3));
            repeat (3) @(posedge clk_i);
            chk(16'(simple_cmp_o), n[0] ? 16'h0007 : 16'h0000);
            chk(16'(full_cmp_o), n[0] ? 16'h003F : 16'h0000);
            chk(16'(tmr_cmp_o), n[0] ? 16'h0007 : 16'h0000);
        end
        wr(5'h00, 16'(M_CONT_UP));
        wr(5'h03, 16'h0009);
        wr(A_IMASK, 16'h0008);
        wr(A_GCTRL, 16'h0001);
        for (n = 0; n < 40 && irq_o !== 1'b1; n++) @(posedge clk_i);
        chk(16'(irq_o), 16'h0001);
        wr(A_GCTRL, 16'h0000);
        wr(A_IMASK, 16'h0000);
        rdchk(A_ISTAT, 16'h0008);
        wr(A_ISTAT, 16'hFFFF);
        rdchk(A_ISTAT, 16'h0000);
        wr(A_DBCR, 16'h0004);
        wr(A_FCMP0, 16'h0005);
        wr(A_FACT, 16'h0AAA);
        wr(5'h03, 16'h0014);
        wr(5'h00, 16'(M_CONT_UD));
        wr(A_GCTRL, 16'h0001);
        n = 0;
        m = 0;
        p = 1'b1;
        repeat (200) begin
            @(posedge clk_i);
            #1;
            if (full_cmp_o[0] && full_cmp_o[1]) n++;
            if (full_cmp_o[0] && !p) m++;
            p = full_cmp_o[0];
        end
        chk(16'(n), 16'h0000);
        chk(16'(m >= 3), 16'h0001);
        wr(A_GCTRL, 16'h0000);
        wr(5'h01, 16'h0000);
        dir_up <= 3'h5;
        ext_en <= 1'b1;
        wr(5'h04, 16'(M_DIR_UD));
        wr(5'h07, 16'h001E);
        wr(5'h08, 16'h0042);
        wr(A_GCTRL, 16'h0006);
        repeat (40) @(posedge clk_i);
        rdchk(A_TSTAT, 16'h0002);
        chk(cap_tb_o, 16'h0015);
        rdchk(5'h09, 16'h000A);
        dir_up <= 3'h7;
        repeat (10) @(posedge clk_i);
        rdchk(A_TSTAT, 16'h0000);
        wr(A_GCTRL, 16'h0000);
        wr(5'h05, 16'h0000);
        wr(5'h04, 16'(M_CONT_UP));
        wr(5'h07, 16'h0003);
        wr(5'h09, 16'h0000);
        wr(5'h08, 16'(M_CONT_UP));
        wr(5'h03, 16'h0003);
        wr(5'h00, 16'(M_SGL_UP));
        wr(A_GCTRL, 16'h002F);
        repeat (20) @(posedge clk_i);
        rdchk(A_GCTRL, 16'h002E);
        rdchk(5'h09, 16'h0005);
        chk(cap_tb_o, 16'h0005);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdchk(5'h03, RST_PER);
        rdchk(A_IMASK, 16'h0000);
        give_verdict();
    end
endmodule // etcu_top_tb
